// ==== hw/phy_common_config_regs.sv ====
// common and third configuration registers of the dual port line device
// Operation
// - source 00: crystal, no clock out; 01: crystal, 25 MHz out
// - source 10: external 25 MHz in; 11: 50 MHz reference, no crystal
// - bit 11 zero enables internal core regulator; one means external
// - bit 10 selects standard (0) or reduced (1) clock drive
// - bit 9 keeps crystal and clock out alive until forced or managed sleep
// - bits 8:7 pick local wake filter time, longest by default
// - bit 6 picks absolute (0) or ratiometric (1) wake threshold
// - bit 5 holds inhibit output on in disable mode when set
// - common register reachable only via port zero; port one reads zero
// - clock source and regulator reset values come from straps
// - bit 2 swaps positive and negative lines on both ports
// - writing one to bit 1 forces system sleep, bit self clears
// - bit 0 enables the port, reset value from strap
// - no latch high status bits exist here, so reads clear nothing
`timescale 1ns/1ps
module phy_common_config_regs
  import phy_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // management access, already decoded from the serial frame
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic mgmt_port_one,
  input wire logic [4:0] mgmt_addr,
  input wire logic [phy_cfg_pkg::reg_w-1:0] mgmt_wdata,
  output logic [phy_cfg_pkg::reg_w-1:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // strap pins
  input wire logic [1:0] strap_clk_src,
  input wire logic strap_core_regulator,
  input wire logic strap_port_enable,
  // device state
  input wire logic port_needs_clock,
  input wire logic disable_mode,
  input wire logic sleep_entered,
  // clock and supply control
  output logic xtal_enable,
  output logic clk_out_enable,
  output logic clk_pin_is_input,
  output logic ref_clk_50_select,
  output logic clk_drive_reduced,
  output logic core_regulator_enable,
  // wake and inhibit control
  output logic [1:0] local_wake_filter_time,
  output logic wake_ratiometric,
  output logic inhibit_output,
  // line and port control
  output logic line_polarity_swap,
  output logic force_sleep_pulse,
  output logic port_enable
);
  // positions of each strap inside the captured vector
  localparam int strap_w = 4;
  localparam int strap_clk_src_hi = 3;
  localparam int strap_clk_src_lo = 2;
  localparam int strap_core_regulator_pos = 1;
  localparam int strap_port_enable_pos = 0;

  logic [strap_w-1:0] strap_val;
  logic strap_done;
  logic strap_done_d_ff;
  logic [15:0] common_ff;
  logic [15:0] third_ff;
  logic force_sleep_ff;
  logic keep_alive_hold_ff;
  logic [15:0] mgmt_rdata_ff;
  logic mgmt_rvalid_ff;
  logic wr_common;
  logic wr_third;
  logic load_strap;
  logic [1:0] clk_src;
  logic [15:0] nxt_rdata;

  strap_capture #(.width(strap_w)) u_strap (
    .clk_sys(clk_sys),
    .rst(rst),
    .strap_in({strap_clk_src, strap_core_regulator, strap_port_enable}),
    .strap_val(strap_val),
    .strap_done(strap_done)
  );

  // port one gets no write path to the common register
  assign wr_common = mgmt_wr && !mgmt_port_one
    && mgmt_addr == common_configuration_addr;
  assign wr_third = mgmt_wr && mgmt_addr == port_configuration_three_addr;
  assign load_strap = strap_done && !strap_done_d_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_done_d_ff <= 1'b0;
    end else begin
      strap_done_d_ff <= strap_done;
    end
  end

  // common configuration, strapped fields loaded once after reset
  // a write on the strap load edge is dropped, so hosts start one edge later
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      common_ff <= common_fixed_rst;
      common_ff[wake_ratiometric_bit] <= wake_ratiometric_rst;
    end else if (load_strap) begin
      common_ff[clk_src_hi:clk_src_lo] <=
        strap_val[strap_clk_src_hi:strap_clk_src_lo];
      common_ff[core_regulator_select_bit] <=
        strap_val[strap_core_regulator_pos];
    end else if (wr_common) begin
      // reserved and foreign bits are never stored
      common_ff <= mgmt_wdata & common_wr_mask;
    end
  end

  // third configuration: polarity and enable stored, sleep bit not stored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      third_ff <= read_zero;
    end else if (load_strap) begin
      third_ff[port_enable_bit] <=
        strap_val[strap_port_enable_pos];
    end else if (wr_third) begin
      third_ff <= mgmt_wdata & third_wr_mask;
    end
  end

  // self clearing forced sleep, one cycle command
  // back to back sleep writes stretch the pulse, one cycle per write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      force_sleep_ff <= 1'b0;
    end else begin
      force_sleep_ff <= wr_third && mgmt_wdata[force_sleep_bit];
    end
  end

  // keep-alive hold drops on a forced sleep pulse or once a managed sleep has been entered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keep_alive_hold_ff <= 1'b1;
    end else if (force_sleep_ff || sleep_entered) begin
      keep_alive_hold_ff <= 1'b0;
    end else if (port_needs_clock) begin
      keep_alive_hold_ff <= 1'b1;
    end
  end

  // read mux; port one sees zero for the common register
  always_comb begin
    nxt_rdata = read_zero;
    if (mgmt_addr == common_configuration_addr && !mgmt_port_one) begin
      nxt_rdata = common_ff;
    end else if (mgmt_addr == port_configuration_three_addr) begin
      // sleep bit reads zero since it is never stored in the register
      nxt_rdata = third_ff;
    end
  end

  // read data registered; no latch-high flags live here, so reads clear none
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mgmt_rdata_ff <= read_zero;
      mgmt_rvalid_ff <= 1'b0;
    end else begin
      mgmt_rvalid_ff <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata_ff <= nxt_rdata;
      end
    end
  end

  assign mgmt_rdata = mgmt_rdata_ff;
  assign mgmt_rvalid = mgmt_rvalid_ff;
  assign clk_src = common_ff[clk_src_hi:clk_src_lo];

  // clock source decode; keep-alive overrides gating when set, until a sleep drops the hold
  always_comb begin
    xtal_enable = 1'b0;
    clk_out_enable = 1'b0;
    clk_pin_is_input = 1'b0;
    ref_clk_50_select = 1'b0;
    case (clk_src)
      clk_xtal_no_out: begin
        xtal_enable = 1'b1;
      end
      clk_xtal_out: begin
        xtal_enable = 1'b1;
        clk_out_enable = 1'b1;
      end
      clk_ext_in: begin
        clk_pin_is_input = 1'b1;
      end
      clk_ref_50: begin
        ref_clk_50_select = 1'b1;
      end
      default: begin
        xtal_enable = 1'b1;
      end
    endcase
    // gate crystal and clock out when idle unless held alive
    if (!port_needs_clock && !(common_ff[clk_keep_alive_bit]
        && keep_alive_hold_ff)) begin
      xtal_enable = 1'b0;
      clk_out_enable = 1'b0;
    end
  end

  assign clk_drive_reduced = common_ff[clk_drive_reduced_bit];
  assign core_regulator_enable =
    !common_ff[core_regulator_select_bit];
  assign local_wake_filter_time =
    common_ff[local_wake_filter_time_hi:local_wake_filter_time_lo];
  assign wake_ratiometric = common_ff[wake_ratiometric_bit];
  // outside disable mode the inhibit output stays on
  assign inhibit_output = !disable_mode
    || common_ff[inhibit_in_disable_bit];
  assign line_polarity_swap = third_ff[line_polarity_swap_bit];
  assign force_sleep_pulse = force_sleep_ff;
  assign port_enable = third_ff[port_enable_bit];
endmodule

// ==== hw/strap_capture.sv ====
// one-shot capture of strap levels after reset release
`timescale 1ns/1ps
module strap_capture #(
  parameter int width = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // strap levels and captured copy
  input wire logic [width-1:0] strap_in,
  output logic [width-1:0] strap_val,
  output logic strap_done
);
  logic [width-1:0] val_ff;
  logic done_ff;

  // async reset only loads constants, the strap is caught on the first edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      val_ff <= '0;
      done_ff <= 1'b0;
    end else if (!done_ff) begin
      val_ff <= strap_in;
      done_ff <= 1'b1;
    end
  end

  assign strap_val = val_ff;
  assign strap_done = done_ff;
endmodule

// ==== pkg/phy_cfg_pkg.sv ====
// constants for the common and third configuration registers
package phy_cfg_pkg;
  localparam logic [4:0] common_configuration_addr = 5'h1b;
  localparam logic [4:0] port_configuration_three_addr = 5'h1c;
  localparam int reg_w = 16;
  // common configuration field positions
  localparam int clk_src_hi = 13;
  localparam int clk_src_lo = 12;
  localparam int core_regulator_select_bit = 11;
  localparam int clk_drive_reduced_bit = 10;
  localparam int clk_keep_alive_bit = 9;
  localparam int local_wake_filter_time_hi = 8;
  localparam int local_wake_filter_time_lo = 7;
  localparam int wake_ratiometric_bit = 6;
  localparam int inhibit_in_disable_bit = 5;
  // writable bits of common configuration (upper fields belong elsewhere)
  localparam logic [15:0] common_wr_mask = 16'h3fe0;
  // third configuration register field positions
  localparam int line_polarity_swap_bit = 2;
  localparam int force_sleep_bit = 1;
  localparam int port_enable_bit = 0;
  localparam logic [15:0] third_wr_mask = 16'h0005;
  // clock source codes
  localparam logic [1:0] clk_xtal_no_out = 2'h0;
  localparam logic [1:0] clk_xtal_out = 2'h1;
  localparam logic [1:0] clk_ext_in = 2'h2;
  localparam logic [1:0] clk_ref_50 = 2'h3;
  // fixed reset values of non-strapped fields
  localparam logic [15:0] common_fixed_rst = 16'h0000;
  localparam logic [1:0] wake_filter_rst = 2'h0;
  localparam logic wake_ratiometric_rst = 1'b1;
  localparam logic [2:0] wake_filter_sel_w = 3'h0;
  localparam logic [15:0] read_zero = 16'h0000;
endpackage

// ==== verification/mgmt_host_model.sv ====
// station management host issuing decoded register accesses
`timescale 1ns/1ps
module mgmt_host_model (
  // clock
  input wire logic clk_sys,
  // decoded management access
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic mgmt_port_one,
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  // strobes idle low from time zero
  initial begin
    {mgmt_wr, mgmt_rd, mgmt_port_one, mgmt_addr, mgmt_wdata} = '0;
  end
  // whole 16-bit word per write, strobe held for one edge
  task automatic wr(input logic p, input logic [4:0] a,
                    input logic [15:0] v);
    @(posedge clk_sys);
    {mgmt_port_one, mgmt_addr, mgmt_wdata} <= {p, a, v};
    mgmt_wr <= 1'b1;
    @(posedge clk_sys);
    mgmt_wr <= 1'b0;
  endtask
  // answer counts only while rvalid stands, else unknown comes back
  task automatic rd(input logic p, input logic [4:0] a,
                    output logic [15:0] v);
    @(posedge clk_sys);
    {mgmt_port_one, mgmt_addr} <= {p, a};
    mgmt_rd <= 1'b1;
    @(posedge clk_sys);
    mgmt_rd <= 1'b0;
    #1 v = (mgmt_rvalid === 1'b1) ? mgmt_rdata : 'x;
  endtask
endmodule

// ==== verification/phy_common_config_regs_assertions.sv ====
// port checker for the configuration register block
`timescale 1ns/1ps
module phy_cfg_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // management access
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic mgmt_port_one,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  // controls
  input wire logic disable_mode,
  input wire logic xtal_enable,
  input wire logic clk_out_enable,
  input wire logic clk_pin_is_input,
  input wire logic ref_clk_50_select,
  input wire logic [1:0] local_wake_filter_time,
  input wire logic inhibit_output,
  input wire logic line_polarity_swap,
  input wire logic force_sleep_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] wdata_ff;
  // write data of the previous cycle, for field compares
  always_ff @(posedge clk_sys) begin
    wdata_ff <= mgmt_wdata;
  end
  AST_RVALID: assert property (mgmt_rd |=> mgmt_rvalid)
    else $error("read not answered");
  AST_P1_ZERO: assert property (mgmt_rd && mgmt_port_one &&
    mgmt_addr == 5'h1b |=> mgmt_rdata == 16'h0000)
    else $error("port one read not zero");
  AST_THIRD_RSVD: assert property (mgmt_rd && mgmt_addr == 5'h1c
    |=> (mgmt_rdata & 16'hfffa) == 16'h0000)
    else $error("third register unused bits set");
  AST_SLEEP: assert property (mgmt_wr && mgmt_addr == 5'h1c &&
    mgmt_wdata[1] |=> force_sleep_pulse)
    else $error("forced sleep pulse missing");
  AST_SLEEP_SC: assert property (!(mgmt_wr && mgmt_addr == 5'h1c &&
    mgmt_wdata[1]) |=> !force_sleep_pulse)
    else $error("forced sleep did not clear");
  AST_SWAP: assert property (mgmt_wr && !mgmt_port_one &&
    mgmt_addr == 5'h1c |=> line_polarity_swap == wdata_ff[2])
    else $error("line swap not written");
  AST_WAKE: assert property (mgmt_wr && !mgmt_port_one &&
    mgmt_addr == 5'h1b |=> local_wake_filter_time == wdata_ff[8:7])
    else $error("wake filter not written");
  AST_INH: assert property (!disable_mode |-> inhibit_output)
    else $error("inhibit off outside disable");
  AST_REF50: assert property (ref_clk_50_select |->
    !xtal_enable && !clk_out_enable)
    else $error("crystal or clock out with reference");
  AST_CLKIN: assert property (clk_pin_is_input |->
    !clk_out_enable && !ref_clk_50_select)
    else $error("clock pin driven while input");
  cover property (force_sleep_pulse);
  cover property (ref_clk_50_select);
  cover property (mgmt_rvalid && mgmt_port_one);
endmodule
bind phy_common_config_regs phy_cfg_chk u_chk (.clk_sys, .rst, .mgmt_wr,
  .mgmt_rd, .mgmt_port_one, .mgmt_addr, .mgmt_wdata, .mgmt_rdata,
  .mgmt_rvalid, .disable_mode, .xtal_enable, .clk_out_enable,
  .clk_pin_is_input, .ref_clk_50_select, .local_wake_filter_time,
  .inhibit_output, .line_polarity_swap, .force_sleep_pulse);

// ==== verification/phy_common_config_regs_tb.sv ====
// register bench for the configuration register block
`timescale 1ns/1ps
module phy_common_config_regs_tb;
  import phy_cfg_pkg::*;
  logic clk_sys, rst, mgmt_wr, mgmt_rd, mgmt_port_one, mgmt_rvalid;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, d, e;
  logic [1:0] strap_clk_src, local_wake_filter_time;
  logic strap_core_regulator, strap_port_enable, port_needs_clock;
  logic disable_mode, sleep_entered, xtal_enable, clk_out_enable;
  logic clk_pin_is_input, ref_clk_50_select, clk_drive_reduced;
  logic core_regulator_enable, wake_ratiometric, inhibit_output;
  logic line_polarity_swap, force_sleep_pulse, port_enable;
  int errors, checked;
  phy_common_config_regs u_dut (.clk_sys, .rst, .mgmt_wr, .mgmt_rd,
    .mgmt_port_one, .mgmt_addr, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid,
    .strap_clk_src, .strap_core_regulator, .strap_port_enable,
    .port_needs_clock, .disable_mode, .sleep_entered, .xtal_enable,
    .clk_out_enable, .clk_pin_is_input, .ref_clk_50_select,
    .clk_drive_reduced, .core_regulator_enable, .local_wake_filter_time,
    .wake_ratiometric, .inhibit_output, .line_polarity_swap,
    .force_sleep_pulse, .port_enable);
  mgmt_host_model u_host (.clk_sys, .mgmt_wr, .mgmt_rd, .mgmt_port_one,
    .mgmt_addr, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid);
  task automatic chk(input string n, input logic [15:0] s, x);
    checked++;
    if (s !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // 200 MHz system clock
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // about 61 cycles suffice; a hang past 4000 cycles (20 us) is a failure
  initial begin
    #20000;
    errors++;
    summarize;
  end
  // straps pick crystal with clock out, external core supply, port on
  initial begin
    {rst, strap_clk_src, strap_core_regulator} = 4'hf;
    {strap_clk_src, strap_port_enable, port_needs_clock} = 4'h7;
    {disable_mode, sleep_entered} = 2'h2;
    repeat (4) @(posedge clk_sys);
    rst <= 0;
    repeat (3) @(posedge clk_sys);
    u_host.rd(0, 5'h1b, d);
    chk("common", d, 16'h1840);
    u_host.rd(0, 5'h1c, d);
    chk("third", d, 16'h0001);
    chk("clk_out", clk_out_enable, 1'b1);
    chk("core_reg", core_regulator_enable, 1'b0);
    chk("inhibit", inhibit_output, 1'b0);
    $display("test reset done");
    // every clock code and wake code, other writable bits toggled with them
    for (int i = 0; i < 4; i++) begin
      d = {2'h3, i[1:0], {3{i[0]}}, i[1:0], ~i[0], i[0], 5'h1f};
      e = d & common_wr_mask;
      u_host.wr(0, 5'h1b, d);
      u_host.rd(0, 5'h1b, d);
      chk("common", d, e);
      chk("clk_out", clk_out_enable, i == 1);
      chk("clk_in", clk_pin_is_input, i == 2);
      chk("ref50", ref_clk_50_select, i == 3);
      chk("core_reg", core_regulator_enable, !i[0]);
      chk("drive", clk_drive_reduced, i[0]);
      chk("wake_tim", local_wake_filter_time, i[1:0]);
      chk("ratio", wake_ratiometric, !i[0]);
      chk("inhibit", inhibit_output, i[0]);
    end
    $display("test fields done");
    u_host.wr(0, 5'h1b, 16'h1000);
    port_needs_clock <= 0;
    @(posedge clk_sys);
    #1 chk("clk_gate", clk_out_enable, 1'b0);
    @(posedge clk_sys);
    port_needs_clock <= 1;
    u_host.wr(1, 5'h1b, 16'h0000);
    u_host.rd(1, 5'h1b, d);
    chk("p1_read", d, 16'h0000);
    u_host.rd(0, 5'h1b, d);
    chk("p0_kept", d, 16'h1000);
    u_host.rd(0, 5'h1b, d);
    chk("reread", d, 16'h1000);
    u_host.rd(0, 5'h1d, d);
    chk("unmapped", d, 16'h0000);
    $display("test access done");
    // keep-alive holds crystal and clock out while idle until sleep
    u_host.wr(0, 5'h1b, 16'h1200);
    port_needs_clock <= 0;
    @(posedge clk_sys);
    #1 chk("xtal_hold", xtal_enable, 1'b1);
    chk("clk_hold", clk_out_enable, 1'b1);
    u_host.wr(0, 5'h1c, 16'h0002);
    #1 chk("sleep_pulse", force_sleep_pulse, 1'b1);
    @(posedge clk_sys);
    #1 chk("sleep_clear", force_sleep_pulse, 1'b0);
    chk("xtal_slept", xtal_enable, 1'b0);
    chk("clk_slept", clk_out_enable, 1'b0);
    // a port needing the clock re-arms the hold, a sleep drops it again
    @(posedge clk_sys);
    port_needs_clock <= 1;
    @(posedge clk_sys);
    port_needs_clock <= 0;
    @(posedge clk_sys);
    #1 chk("clk_rehold", clk_out_enable, 1'b1);
    @(posedge clk_sys);
    sleep_entered <= 1;
    @(posedge clk_sys);
    #1 chk("clk_sleep", clk_out_enable, 1'b0);
    @(posedge clk_sys);
    {sleep_entered, port_needs_clock} <= 2'h1;
    $display("test keep alive done");
    u_host.wr(0, 5'h1c, 16'hffff);
    u_host.rd(0, 5'h1c, d);
    chk("third", d, 16'h0005);
    chk("swap", line_polarity_swap, 1'b1);
    u_host.wr(0, 5'h1c, 16'h0000);
    @(posedge clk_sys);
    chk("port_en", port_enable, 1'b0);
    disable_mode <= 0;
    @(posedge clk_sys);
    #1 chk("inhibit", inhibit_output, 1'b1);
    $display("test third done");
    summarize;
  end
endmodule
